// ==== ac_range_and_adc_control.sv ====
// What this block does
// RULE1: drive two attenuator controls choosing x0.2 or x0.002 first stage.
// RULE2: per-range stage gains: low volt ranges x0.2, high x0.002, currents x0.2/x100.
// RULE3: second stage switch pattern: x1 bypass, x10 two+four, x100 two+three+five.
// RULE4: keep one compensation code per AC voltage range, apply on selection.
// RULE5: compensation is 8-bit, 256 steps, one or both capacitors by attenuator.
// RULE6: force DC amplifier to unity gain in all AC functions.
// RULE7: AC relay routes to input high for voltage, shunt sense for current.
// RULE8: three filter settings from two analog capacitors plus CPU filtering.
// RULE9: fast analog filter always while autoranging in AC functions.
// RULE10: slow analog filter only for slow or medium setting.
// RULE11: frequency and period pass one transition per zero crossing.
// RULE12: disable comparator during AC voltage and current measurement.
// RULE13: CPU ranges frequency/period from 10-bit conversion of AC level.
// RULE14: charge-balance loop runs always, trigger or not.
// RULE15: sample integrator comparator every 2.66 us, one decision per sample.
// RULE16: steer positive or negative reference to hold integrator mid level.
// RULE17: trigger clears slope counter to zero.
// RULE18: latch slope count at end of integration and hold it.
// RULE19: latched count is the upper result, CPU residue conversion the lower.
// RULE20: count up on positive steering, down on negative, over set intervals.
// RULE21: done flag set on latch, cleared by result read or new trigger.
`timescale 1ns/100ps
`include "acadc_params.svh"
module ac_range_and_adc_control #(
  parameter int COUNT_W  = `COUNT_WIDTH,
  parameter int NRANGES  = `NUM_AC_V_RANGES,
  parameter int SAMPLE_N = `SAMPLE_CYCLES
) (
  input  wire logic                     CLK_SYS_IN,
  input  wire logic                     NRST_IN,
  input  wire logic [`FUNC_WIDTH-1:0]   FUNCTION_IN,
  input  wire logic [`RANGE_WIDTH-1:0]  RANGE_IN,
  input  wire logic [1:0]               FILTER_IN,
  input  wire logic                     AUTORANGE_IN,
  input  wire logic                     COMP_WRITE_IN,
  input  wire logic [`RANGE_WIDTH-1:0]  COMP_WRITE_RANGE_IN,
  input  wire logic [7:0]               COMP_WRITE_CODE_IN,
  input  wire logic                     TRIGGER_IN,
  input  wire logic [15:0]              INTERVALS_IN,
  input  wire logic                     RESULT_READ_IN,
  input  wire logic                     INTEGRATOR_COMP_IN,
  input  wire logic                     ZERO_CROSS_COMP_IN,
  output logic                          ATTENUATOR_SELECT_A_OUT,
  output logic                          ATTENUATOR_SELECT_B_OUT,
  output logic                          GAIN_SWITCH_ONE_OUT,
  output logic                          GAIN_SWITCH_TWO_OUT,
  output logic                          GAIN_SWITCH_THREE_OUT,
  output logic                          GAIN_SWITCH_FOUR_OUT,
  output logic                          GAIN_SWITCH_FIVE_OUT,
  output logic [7:0]                    COMPENSATION_CODE_OUT,
  output logic                          EXTRA_COMP_ENABLE_OUT,
  output logic                          DC_AMP_UNITY_OUT,
  output logic                          AC_INPUT_ROUTE_RELAY_OUT,
  output logic                          SLOW_AVERAGE_ENABLE_OUT,
  output logic                          COMPARATOR_DISABLE_OUT,
  output logic                          ZERO_CROSS_PULSE_OUT,
  output logic                          STEER_POSITIVE_OUT,
  output logic                          STEER_NEGATIVE_OUT,
  output logic [COUNT_W-1:0]            SLOPE_COUNT_OUT,
  output logic                          CONVERSION_DONE_OUT,
  output logic                          BUSY_OUT
);

  if (COUNT_W < 17 || NRANGES < 1 || NRANGES > (1 << `RANGE_WIDTH)) begin : g_bad_params
    $error("ac_range_and_adc_control parameters out of range");
  end

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] int_comp_sync;
  logic [1:0] zc_sync;
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      int_comp_sync <= 2'h0;
      zc_sync       <= 2'h0;
    end else begin
      int_comp_sync <= {int_comp_sync[0], INTEGRATOR_COMP_IN};
      zc_sync       <= {zc_sync[0], ZERO_CROSS_COMP_IN};
    end
  end
  wire int_comp = int_comp_sync[1];
  wire zc_level = zc_sync[1];

  // ----------------------------------------------------------------
  // function and range decode
  // ----------------------------------------------------------------
  acadc_pkg::func_e func;
  assign func = acadc_pkg::func_e'(FUNCTION_IN);
  wire is_acv    = (func == acadc_pkg::FUNC_ACV);
  wire is_aci    = (func == acadc_pkg::FUNC_ACI);
  wire is_fp     = (func == acadc_pkg::FUNC_FREQ) || (func == acadc_pkg::FUNC_PERIOD);
  wire is_ac_fn  = is_acv || is_aci || is_fp;
  wire is_v_path = is_acv || is_fp;
  // voltage ranges 0..4: 100 mV, 1 V, 10 V, 100 V, 300 V
  wire high_atten = is_v_path && (RANGE_IN >= `RANGE_WIDTH'(`RANGE_100V)); // [RULE2]
  typedef enum logic [1:0] {
    G_X1,
    G_X10,
    G_X100
  } gain_e;
  gain_e gain;
  always_comb begin
    gain = G_X100;
    if (is_v_path) begin
      case (RANGE_IN)
        `RANGE_WIDTH'(`RANGE_100MV): gain = G_X100;
        `RANGE_WIDTH'(`RANGE_1V):    gain = G_X10;
        `RANGE_WIDTH'(`RANGE_10V):   gain = G_X1;
        `RANGE_WIDTH'(`RANGE_100V):  gain = G_X10;
        `RANGE_WIDTH'(`RANGE_300V):  gain = G_X1;
        default:                     gain = G_X1;
      endcase
    end
  end // [RULE2]
  acadc_pkg::gain_sw_s gsw;
  always_comb begin
    gsw = '0;
    case (gain)
      G_X1:    gsw.one = 1'b1;
      G_X10:   begin
        gsw.two  = 1'b1;
        gsw.four = 1'b1;
      end
      G_X100:  begin
        gsw.two   = 1'b1;
        gsw.three = 1'b1;
        gsw.five  = 1'b1;
      end
      default: gsw = '0;
    endcase
  end // [RULE3]
  acadc_pkg::atten_s att;
  assign att.atten_a = !high_atten; // [RULE1]
  assign att.atten_b = high_atten; // [RULE1]

  // ----------------------------------------------------------------
  // compensation store
  // ----------------------------------------------------------------
  logic [7:0] comp_mem [NRANGES];
  genvar gi;
  generate
    for (gi = 0; gi < NRANGES; gi++) begin : g_comp
      always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
          comp_mem[gi] <= `COMP_CODE_RESET;
        end else if (COMP_WRITE_IN && COMP_WRITE_RANGE_IN == `RANGE_WIDTH'(gi)) begin
          comp_mem[gi] <= COMP_WRITE_CODE_IN; // [RULE4]
        end
      end
    end
  endgenerate
  wire        range_ok  = (RANGE_IN < `RANGE_WIDTH'(NRANGES));
  wire [7:0]  comp_sel  = (is_v_path && range_ok) ? comp_mem[RANGE_IN] : 8'h00; // [RULE4] [RULE5]

  // ----------------------------------------------------------------
  // filter and comparator control
  // ----------------------------------------------------------------
  acadc_pkg::filter_e filt;
  assign filt = acadc_pkg::filter_e'(FILTER_IN);
  wire slow_req  = (filt == acadc_pkg::FILT_SLOW) || (filt == acadc_pkg::FILT_MEDIUM); // [RULE10]
  wire slow_on   = is_ac_fn && slow_req && !AUTORANGE_IN; // [RULE8] [RULE9]
  wire comp_dis  = !is_fp; // [RULE12]
  wire zc_pulse  = is_fp && zc_level; // [RULE11]

  // ----------------------------------------------------------------
  // switch pattern registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ATTENUATOR_SELECT_A_OUT  <= 1'b1;
      ATTENUATOR_SELECT_B_OUT  <= 1'b0;
      {GAIN_SWITCH_ONE_OUT, GAIN_SWITCH_TWO_OUT, GAIN_SWITCH_THREE_OUT,
       GAIN_SWITCH_FOUR_OUT, GAIN_SWITCH_FIVE_OUT} <= `GAIN_SW_RESET;
    end else begin
      ATTENUATOR_SELECT_A_OUT  <= att.atten_a; // [RULE1]
      ATTENUATOR_SELECT_B_OUT  <= att.atten_b; // [RULE1]
      {GAIN_SWITCH_ONE_OUT, GAIN_SWITCH_TWO_OUT, GAIN_SWITCH_THREE_OUT,
       GAIN_SWITCH_FOUR_OUT, GAIN_SWITCH_FIVE_OUT} <= gsw; // [RULE3]
    end
  end

  // ----------------------------------------------------------------
  // compensation registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      COMPENSATION_CODE_OUT    <= 8'h00;
      EXTRA_COMP_ENABLE_OUT    <= 1'b0;
    end else begin
      COMPENSATION_CODE_OUT    <= comp_sel; // [RULE4]
      EXTRA_COMP_ENABLE_OUT    <= high_atten; // [RULE5]
    end
  end

  // ----------------------------------------------------------------
  // routing and filter registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      DC_AMP_UNITY_OUT         <= 1'b0;
      AC_INPUT_ROUTE_RELAY_OUT <= 1'b0;
      SLOW_AVERAGE_ENABLE_OUT  <= 1'b0;
    end else begin
      DC_AMP_UNITY_OUT         <= is_ac_fn; // [RULE6]
      AC_INPUT_ROUTE_RELAY_OUT <= is_aci; // [RULE7]
      SLOW_AVERAGE_ENABLE_OUT  <= slow_on; // [RULE8]
    end
  end

  // ----------------------------------------------------------------
  // zero cross comparator registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      COMPARATOR_DISABLE_OUT   <= 1'b1;
      ZERO_CROSS_PULSE_OUT     <= 1'b0;
    end else begin
      COMPARATOR_DISABLE_OUT   <= comp_dis; // [RULE12]
      ZERO_CROSS_PULSE_OUT     <= zc_pulse; // [RULE11]
    end
  end

  // ----------------------------------------------------------------
  // charge balance converter
  // ----------------------------------------------------------------
  logic tick;
  sample_ticker #(
    .PERIOD (SAMPLE_N)
  ) u_ticker (
    .clk_in   (CLK_SYS_IN),
    .nrst_in  (NRST_IN),
    .tick_out (tick)
  ); // [RULE15] [RULE14]

  typedef enum logic {
    S_IDLE,
    S_INTEG
  } adc_state_e;
  adc_state_e         state;
  adc_state_e         next_state;
  logic [COUNT_W-1:0] slope_cnt;
  logic [15:0]        intervals_left;
  logic               done;
  // high comparator means integrator above midpoint: pull down
  wire                steer_pos = !int_comp; // [RULE16]
  wire                last_int  = tick && (intervals_left == 16'h0001);
  wire [15:0]         n_int     = (INTERVALS_IN == 16'h0000) ? 16'(`DEFAULT_INTERVALS)
                                                             : INTERVALS_IN;
  wire [COUNT_W-1:0]  step_cnt  = steer_pos ? slope_cnt + COUNT_W'(1)
                                            : slope_cnt - COUNT_W'(1); // [RULE20]
  always_comb begin
    next_state = state;
    case (state)
      S_IDLE:  if (TRIGGER_IN) next_state = S_INTEG;
      S_INTEG: if (last_int && !TRIGGER_IN) next_state = S_IDLE; // [RULE17]
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      STEER_POSITIVE_OUT <= 1'b0;
      STEER_NEGATIVE_OUT <= 1'b0;
    end else if (tick) begin
      STEER_POSITIVE_OUT <= steer_pos; // [RULE14] [RULE16]
      STEER_NEGATIVE_OUT <= !steer_pos;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      state          <= S_IDLE;
      slope_cnt      <= '0;
      intervals_left <= 16'h0000;
    end else begin
      state <= next_state;
      if (TRIGGER_IN) begin
        slope_cnt      <= '0; // [RULE17]
        intervals_left <= n_int;
      end else if (state == S_INTEG && tick) begin
        slope_cnt      <= step_cnt; // [RULE20]
        intervals_left <= intervals_left - 16'h0001;
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      SLOPE_COUNT_OUT <= '0;
      done            <= 1'b0;
    end else begin
      if (state == S_INTEG && last_int && !TRIGGER_IN) begin
        SLOPE_COUNT_OUT <= step_cnt; // [RULE18] [RULE19]
        done            <= 1'b1; // [RULE21]
      end else if (RESULT_READ_IN || TRIGGER_IN) begin
        done            <= 1'b0; // [RULE21]
      end
    end
  end
  assign CONVERSION_DONE_OUT = done;

  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      BUSY_OUT <= 1'b0;
    end else begin
      BUSY_OUT <= (next_state == S_INTEG);
    end
  end

endmodule : ac_range_and_adc_control

// ==== acadc_assertions.sv ====
`timescale 1ns/100ps
`include "acadc_params.svh"
module acadc_assertions #(
  parameter int SAMPLE_N = `SAMPLE_CYCLES
) (
  input wire logic                   CLK_SYS_IN,
  input wire logic                   NRST_IN,
  input wire logic [`FUNC_WIDTH-1:0] FUNCTION_IN,
  input wire logic [1:0]             FILTER_IN,
  input wire logic                   AUTORANGE_IN,
  input wire logic                   TRIGGER_IN,
  input wire logic                   RESULT_READ_IN,
  input wire logic                   ATTENUATOR_SELECT_A_OUT,
  input wire logic                   ATTENUATOR_SELECT_B_OUT,
  input wire logic                   GAIN_SWITCH_ONE_OUT,
  input wire logic                   GAIN_SWITCH_TWO_OUT,
  input wire logic                   GAIN_SWITCH_THREE_OUT,
  input wire logic                   GAIN_SWITCH_FOUR_OUT,
  input wire logic                   GAIN_SWITCH_FIVE_OUT,
  input wire logic                   EXTRA_COMP_ENABLE_OUT,
  input wire logic                   DC_AMP_UNITY_OUT,
  input wire logic                   AC_INPUT_ROUTE_RELAY_OUT,
  input wire logic                   SLOW_AVERAGE_ENABLE_OUT,
  input wire logic                   COMPARATOR_DISABLE_OUT,
  input wire logic                   ZERO_CROSS_PULSE_OUT,
  input wire logic                   STEER_POSITIVE_OUT,
  input wire logic                   STEER_NEGATIVE_OUT,
  input wire logic                   CONVERSION_DONE_OUT,
  input wire logic                   BUSY_OUT
);
  // ----------------------------------------
  // decode and steering spacing helper
  // ----------------------------------------
  wire logic       ac_meas = FUNCTION_IN inside {acadc_pkg::FUNC_ACV, acadc_pkg::FUNC_ACI};
  wire logic       ac_fn   = ac_meas || FUNCTION_IN inside {acadc_pkg::FUNC_FREQ,
                                                           acadc_pkg::FUNC_PERIOD};
  wire logic [4:0] gsw     = {GAIN_SWITCH_ONE_OUT, GAIN_SWITCH_TWO_OUT, GAIN_SWITCH_THREE_OUT,
                              GAIN_SWITCH_FOUR_OUT, GAIN_SWITCH_FIVE_OUT};
  int   cnt;
  logic last_pos;
  logic seen;
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      cnt <= 0;
      last_pos <= 1'b0;
      seen <= 1'b0;
    end else begin
      cnt <= (STEER_POSITIVE_OUT != last_pos) ? 0 : cnt + 1;
      last_pos <= STEER_POSITIVE_OUT;
      seen <= seen || (STEER_POSITIVE_OUT != last_pos);
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!NRST_IN);
  sequence s_trig_start;
    TRIGGER_IN ##1 (BUSY_OUT && !CONVERSION_DONE_OUT);
  endsequence
  sequence s_latch;
    $fell(BUSY_OUT) && CONVERSION_DONE_OUT;
  endsequence
  a_atten_one_hot: assert property (ATTENUATOR_SELECT_A_OUT != ATTENUATOR_SELECT_B_OUT)
    else $error("attenuator selects not exclusive");
  a_gain_pattern_legal: assert property (gsw inside {5'h10, 5'h0a, 5'h0d})
    else $error("illegal gain switch pattern");
  a_extra_comp_match: assert property (EXTRA_COMP_ENABLE_OUT == ATTENUATOR_SELECT_B_OUT)
    else $error("extra compensation not tied to attenuator");
  a_unity_in_ac: assert property (ac_fn |=> DC_AMP_UNITY_OUT)
    else $error("dc amplifier not unity in ac function");
  a_relay_route: assert property (ac_meas |=> AC_INPUT_ROUTE_RELAY_OUT == $past(FUNCTION_IN[1]))
    else $error("ac route relay wrong");
  a_comp_disabled: assert property (ac_meas |=> COMPARATOR_DISABLE_OUT && !ZERO_CROSS_PULSE_OUT)
    else $error("zero cross active in ac measurement");
  a_fast_autorange: assert property (AUTORANGE_IN |=> !SLOW_AVERAGE_ENABLE_OUT)
    else $error("slow filter while autoranging");
  a_fast_no_slow: assert property (FILTER_IN[1] |=> !SLOW_AVERAGE_ENABLE_OUT)
    else $error("slow filter in fast setting");
  a_steer_spacing: assert property ((STEER_POSITIVE_OUT != last_pos) && seen |->
    (cnt + 1) % SAMPLE_N == 0) else $error("steering changed off sample interval");
  a_steer_compl: assert property ((STEER_POSITIVE_OUT || STEER_NEGATIVE_OUT) |=>
    STEER_POSITIVE_OUT != STEER_NEGATIVE_OUT) else $error("steering not complementary");
  a_trigger_clears: assert property (TRIGGER_IN |-> s_trig_start)
    else $error("trigger did not start conversion");
  a_done_on_latch: assert property ($rose(CONVERSION_DONE_OUT) |-> s_latch)
    else $error("done without end of integration");
  a_read_clears: assert property (RESULT_READ_IN && !BUSY_OUT |=> !CONVERSION_DONE_OUT)
    else $error("read did not clear done");
endmodule : acadc_assertions

bind ac_range_and_adc_control acadc_assertions #(.SAMPLE_N(SAMPLE_N)) u_chk (.*);

// ==== acadc_far_side.sv ====
`timescale 1ns/100ps
module acadc_far_side (
  input  wire logic              clk_in,
  input  wire logic              steer_pos_in,
  input  wire logic              steer_neg_in,
  input  wire logic signed [7:0] vin_in,
  input  wire logic              zc_en_in,
  output logic                   comp_out = 1'b0,
  output logic                   zc_out = 1'b0
);
  // ----------------------------------------
  // integrator with clamped swing, zero cross source
  // ----------------------------------------
  int acc = 0;
  int ph = 0;
  int nxt;
  always_comb nxt = acc + vin_in + (steer_pos_in ? 20 : 0) - (steer_neg_in ? 20 : 0);
  always @(posedge clk_in) begin
    acc <= (nxt > 100) ? 100 : ((nxt < -100) ? -100 : nxt);
    comp_out <= acc > 0;
    ph <= (ph == 4) ? 0 : ph + 1;
    if (!zc_en_in) zc_out <= 1'b0;
    else if (ph == 4) zc_out <= ~zc_out;
  end
endmodule : acadc_far_side

// ==== acadc_params.svh ====
`ifndef ACADC_PARAMS_SVH
`define ACADC_PARAMS_SVH
`define CLK_PERIOD_NS      10
`define SAMPLE_INTERVAL_NS 2660
`define SAMPLE_CYCLES      (`SAMPLE_INTERVAL_NS / `CLK_PERIOD_NS)
`define DEFAULT_INTERVALS  1024
`define COMP_CODE_RESET    8'h80
`define COUNT_WIDTH        24
`define RANGE_WIDTH        3
`define FUNC_WIDTH         3
`define NUM_AC_V_RANGES    5
`define RANGE_100MV        0
`define RANGE_1V           1
`define RANGE_10V          2
`define RANGE_100V         3
`define RANGE_300V         4
`define GAIN_SW_RESET      5'h10
`endif

// ==== acadc_pkg.sv ====
package acadc_pkg;
  typedef enum logic [2:0] {
    FUNC_DCV,
    FUNC_ACV,
    FUNC_ACI,
    FUNC_FREQ,
    FUNC_PERIOD,
    FUNC_OTHER
  } func_e;
  typedef enum logic [1:0] {
    FILT_SLOW,
    FILT_MEDIUM,
    FILT_FAST
  } filter_e;
  typedef struct packed {
    logic atten_a;
    logic atten_b;
  } atten_s;
  typedef struct packed {
    logic one;
    logic two;
    logic three;
    logic four;
    logic five;
  } gain_sw_s;
endpackage : acadc_pkg

// ==== sample_ticker.sv ====
`timescale 1ns/100ps
`include "acadc_params.svh"
module sample_ticker #(
  parameter int PERIOD = `SAMPLE_CYCLES
) (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  output logic      tick_out
);
  if (PERIOD < 2) begin : g_bad_period
    $error("sample_ticker period too small");
  end
  localparam int W = $clog2(PERIOD);
  logic [W-1:0] cnt;
  wire          wrap = (cnt == W'(PERIOD - 1));
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt      <= '0;
      tick_out <= 1'b0;
    end else begin
      cnt      <= wrap ? '0 : cnt + W'(1);
      tick_out <= wrap;
    end
  end
endmodule : sample_ticker

// ==== tb.sv ====
`timescale 1ns/100ps
module tb;
  localparam int SN = 8;
  logic clk, nrst, ar, cw, trig, rd, icomp, zc, zc_en;
  logic [2:0] func, rng, cwr;
  logic [1:0] filt;
  logic [7:0] cwc, code;
  logic [15:0] ivals;
  logic signed [7:0] vin;
  logic atta, attb, extra, unity, relay, slow, cdis, zco, sp, sn, done, busy;
  wire acadc_pkg::gain_sw_s gs;
  logic [23:0] cnt;
  int num_errors = 0, cmp_count = 0, cyc = 0, n_in = 0, n_out = 0;
  logic [4:0] gtab [5] = '{5'h0d, 5'h0a, 5'h10, 5'h0a, 5'h10};
  ac_range_and_adc_control #(.SAMPLE_N(SN)) u_dut (
    .CLK_SYS_IN(clk), .NRST_IN(nrst), .FUNCTION_IN(func), .RANGE_IN(rng), .FILTER_IN(filt),
    .AUTORANGE_IN(ar), .COMP_WRITE_IN(cw), .COMP_WRITE_RANGE_IN(cwr), .COMP_WRITE_CODE_IN(cwc),
    .TRIGGER_IN(trig), .INTERVALS_IN(ivals), .RESULT_READ_IN(rd), .INTEGRATOR_COMP_IN(icomp),
    .ZERO_CROSS_COMP_IN(zc), .ATTENUATOR_SELECT_A_OUT(atta), .ATTENUATOR_SELECT_B_OUT(attb),
    .GAIN_SWITCH_ONE_OUT(gs.one), .GAIN_SWITCH_TWO_OUT(gs.two), .GAIN_SWITCH_THREE_OUT(gs.three),
    .GAIN_SWITCH_FOUR_OUT(gs.four), .GAIN_SWITCH_FIVE_OUT(gs.five), .COMPENSATION_CODE_OUT(code),
    .EXTRA_COMP_ENABLE_OUT(extra), .DC_AMP_UNITY_OUT(unity), .AC_INPUT_ROUTE_RELAY_OUT(relay),
    .SLOW_AVERAGE_ENABLE_OUT(slow), .COMPARATOR_DISABLE_OUT(cdis), .ZERO_CROSS_PULSE_OUT(zco),
    .STEER_POSITIVE_OUT(sp), .STEER_NEGATIVE_OUT(sn), .SLOPE_COUNT_OUT(cnt),
    .CONVERSION_DONE_OUT(done), .BUSY_OUT(busy));
  acadc_far_side u_far (.clk_in(clk), .steer_pos_in(sp), .steer_neg_in(sn), .vin_in(vin),
    .zc_en_in(zc_en), .comp_out(icomp), .zc_out(zc));
  // ----------------------------------------
  // clock, timeout, edge counters
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      conclude();
    end
  end
  always @(posedge zc) n_in++;
  always @(posedge zco) n_out++;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic cfg(input logic [2:0] f, input logic [2:0] r, input logic [1:0] fl, input logic a);
    @(posedge clk);
    func <= f;
    rng <= r;
    filt <= fl;
    ar <= a;
    step(1);
  endtask : cfg
  task automatic pulse(input bit sel_rd);
    @(posedge clk);
    if (sel_rd) rd <= 1'b1;
    else trig <= 1'b1;
    @(posedge clk);
    {trig, rd} <= 2'b00;
  endtask : pulse
  task automatic convert(input logic [15:0] n, input logic signed [7:0] v, input logic rst);
    @(posedge clk);
    vin <= v;
    ivals <= n;
    step(4 * SN);
    if (rst) begin
      pulse(1'b0);
      step(2 * SN);
    end
    pulse(1'b0);
    step(1);
    for (int i = 0; i < 9000 && done !== 1'b1; i++) step(1);
    chk(done, 1'b1);
  endtask : convert
  task automatic conclude();
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {nrst, ar, cw, trig, rd, zc_en, func, rng, cwr, filt, cwc, vin} = '0;
    ivals = 16'h0003;
    step(5);
    chk({atta, attb, extra, unity, relay, slow, cdis, zco, sp, sn, done, busy}, 12'h820);
    chk(gs, 5'h10);
    @(posedge clk);
    nrst <= 1'b1;
    cfg(3'h1, 3'h0, 2'h2, 1'b0);
    chk(code, 8'h80);
    zc_en <= 1'b1;
    for (int r = 0; r < 5; r++) begin
      cfg(3'h1, r[2:0], 2'h2, 1'b0);
      chk({atta, attb, extra}, (r >= 3) ? 3'h3 : 3'h4);
      chk(gs, gtab[r]);
      chk({unity, relay, cdis, zco}, 4'ha);
      chk(code, 8'h80);
    end
    zc_en <= 1'b0;
    cfg(3'h2, 3'h4, 2'h2, 1'b0);
    chk({atta, attb, gs, unity, relay, cdis}, 10'h26f);
    for (int r = 0; r < 5; r++) pulse_comp(r[2:0]);
    for (int r = 0; r < 5; r++) begin
      cfg(3'h1, r[2:0], 2'h2, 1'b0);
      chk(code, 8'h31 + r[7:0]);
    end
    for (int fn = 1; fn < 5; fn++) begin
      for (int f = 0; f < 4; f++) begin
        cfg(fn[2:0], 3'h1, f[1:0], 1'b0);
        chk(slow, f < 2);
        cfg(fn[2:0], 3'h1, f[1:0], 1'b1);
        chk(slow, 1'b0);
      end
    end
    for (int fn = 3; fn < 5; fn++) begin
      cfg(fn[2:0], 3'h0, 2'h2, 1'b0);
      chk({cdis, unity}, 2'h1);
      {n_in, n_out} = '0;
      zc_en <= 1'b1;
      step(100);
      zc_en <= 1'b0;
      step(10);
      chk(n_out, n_in);
    end
    convert(16'h0003, -8'sd40, 1'b0);
    chk(cnt, 24'h000003);
    pulse(1'b1);
    step(1);
    chk(done, 1'b0);
    convert(16'h0003, -8'sd40, 1'b1);
    chk(cnt, 24'h000003);
    convert(16'h0000, 8'sd40, 1'b0);
    chk(cnt, 24'hfffc00);
    convert(16'h0010, 8'sd0, 1'b0);
    chk($signed(cnt) <= 2 && $signed(cnt) >= -2, 1'b1);
    conclude();
  end
  task automatic pulse_comp(input logic [2:0] r);
    @(posedge clk);
    cw <= 1'b1;
    cwr <= r;
    cwc <= 8'h31 + {5'h00, r};
    @(posedge clk);
    cw <= 1'b0;
  endtask : pulse_comp
endmodule : tb
